//--- ascv_pkg.sv
// Constants, register map and types of the converter sequencer.
// Assumes a 100 MHz peripheral clock and a 16-bit register port.
//
// Notes on behaviour
// R1 - Each conversion outcome is a 10-bit value, right-justified in the result; with res_low set the code uses only the top 8 bits.
// R2 - Channel and reference selection reach the converter only once it is enabled.
// R3 - Writing one starts a conversion; start bit reads one while converting.
// R4 - In single mode hardware clears the start bit at completion.
// R5 - A channel change mid-conversion waits until that conversion ends.
// R6 - Completion of the whole sample or burst sets the result-ready flag.
// R7 - Interrupt requested only while result-ready flag and its enable are set; the code also raises irq for the window flag and its enable.
// R8 - With event start enabled, an incoming event edge sets the start bit.
// R9 - Free-running: software start first, then back-to-back conversions, each flagged.
// R10 - Prescaler counts only while enabled, held at zero otherwise.
// R11 - Prescaler held in reset when idle; conversion begins one clock after trigger.
// R12 - Conversion takes 13 converter cycles; sampling starts the conversion.
// R13 - Reading the result or writing one to the flag clears result-ready.
// R14 - Sampling lasts 2 plus sample delay plus sample length converter cycles.
// R15 - Free-running period is 13 plus sample delay plus sample length cycles.
// R16 - Up to 64 outcomes can be summed into one result.
// R17 - Optional pseudo-random variation of the inter-sample delay.
// R18 - Window compare flags results under, over, inside or outside thresholds.
// R19 - Software keeps the converter clock between 50 kHz and 1.5 MHz.
// R20 - Software configures everything first and sets enable last.
// R21 - Selections are locked during conversion, updated again in its last cycle.
// R22 - When accumulating, the window compare runs once after the last sample.
// R23 - A trigger during a running conversion is ignored.

`default_nettype none

package ascv_pkg;
    // Register offsets
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_ACCUM    = 4'h1;
    localparam logic [3:0] OFS_CLKREF   = 4'h2;
    localparam logic [3:0] OFS_SDELAY   = 4'h3;
    localparam logic [3:0] OFS_SLEN     = 4'h4;
    localparam logic [3:0] OFS_CHAN     = 4'h5;
    localparam logic [3:0] OFS_CMD      = 4'h6;
    localparam logic [3:0] OFS_EVCTRL   = 4'h7;
    localparam logic [3:0] OFS_IRQEN    = 4'h8;
    localparam logic [3:0] OFS_FLAGS    = 4'h9;
    localparam logic [3:0] OFS_RESULT   = 4'ha;
    localparam logic [3:0] OFS_WINLO    = 4'hb;
    localparam logic [3:0] OFS_WINHI    = 4'hc;
    localparam logic [3:0] OFS_WINMODE  = 4'hd;
    // Field positions
    localparam int BIT_ENABLE  = 0;
    localparam int BIT_CONT    = 1;
    localparam int BIT_RESLOW  = 2;
    localparam int BIT_VARY    = 4;
    localparam int BIT_RESULT_READY_FLAG  = 0;
    localparam int BIT_WINDOW  = 1;
    localparam int POS_REF     = 4;
    // Reset values
    localparam logic [15:0] RST_REG  = 16'h0000;
    localparam logic [15:0] RST_WINHI = 16'hffff;
    // Timing in converter clock cycles; accumulation limit, prescaler minimum and LFSR seed
    localparam logic [6:0] CONV_BASE = 7'h0d;
    localparam logic [6:0] SAMP_BASE = 7'h02;
    localparam logic [2:0] ACC_MAX   = 3'h6;
    localparam logic [8:0] DIV_MIN   = 9'h002;
    localparam logic [3:0] LFSR_SEED = 4'h1;
    // Window compare modes
    localparam logic [2:0] WIN_OFF   = 3'h0;
    localparam logic [2:0] WIN_BELOW = 3'h1;
    localparam logic [2:0] WIN_ABOVE = 3'h2;
    localparam logic [2:0] WIN_IN    = 3'h3;
    localparam logic [2:0] WIN_OUT   = 3'h4;

    typedef enum logic [0:0] {
        ASCV_IDLE = 1'b0,
        ASCV_RUN  = 1'b1
    } ascv_state_type;
endpackage

`default_nettype wire

//--- ascv_sync.sv
// Two-stage synchroniser for signals from outside the clock domain.
// Assumes the source holds each value for several clock cycles.
`timescale 1ns/1ps
`default_nettype none

module ascv_sync #(
    parameter int W = 1                     // Width
) (
    input  wire logic         clk,          // Clock
    input  wire logic         arst_n,       // Async reset, active low
    input  wire logic [W-1:0] d,            // Asynchronous input
    output logic      [W-1:0] q             // Synchronised output
);
    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // ascv_sync

`default_nettype wire

//--- ascv_seq.sv
// Conversion sequencer: start, timing, accumulation, window compare.
// Assumes an analog front end that presents a stable result word.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ascv_seq #(
    parameter int ADC_BITS = 10             // Converter resolution
) (
    input  wire logic        ref_clk,       // 100 MHz peripheral clock
    input  wire logic        arst_n,        // Async reset, active low
    input  wire logic [3:0]  addr,          // Register address
    input  wire logic [15:0] wdata,         // Write data
    input  wire logic        wr,            // Write strobe
    input  wire logic        rd,            // Read strobe
    output logic      [15:0] rdata,         // Read data, cycle after rd
    input  wire logic        event_in,      // Event network trigger
    input  wire logic [9:0]  adc_data,      // Front-end conversion word
    output logic             irq,           // Interrupt request
    output logic             adc_on,        // Converter powered
    output logic             sample_hold,   // Sampling window
    output logic      [4:0]  chan_out,      // Applied channel
    output logic      [1:0]  ref_out        // Applied reference
);
    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    ascv_pkg::ascv_state_type st;
    logic        enable;
    logic        cont_mode;
    logic        res_low;
    logic [2:0]  acc_sel;
    logic [2:0]  div_sel;
    logic [1:0]  ref_sel;
    logic [3:0]  samp_dly;
    logic        vary_en;
    logic [4:0]  samp_len;
    logic [4:0]  chan_sel;
    logic        ev_en;
    logic [1:0]  irq_en;
    logic [1:0]  flags;
    logic        start;
    logic [15:0] result;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic [2:0]  win_mode;
    logic [8:0]  pcnt;
    logic [6:0]  cyc;
    logic [6:0]  nsamp;
    logic [15:0] acc;
    logic [3:0]  lfsr;
    logic        ev_q;
    logic        ev_d;
    logic [9:0]  data_q;
    logic [8:0]  fac;
    logic        tick;
    logic [4:0]  eff_dly;
    logic [6:0]  total;
    logic [6:0]  samp_time;
    logic [6:0]  need;
    logic        last_cyc;
    logic        done_last;
    logic [15:0] smp;
    logic [15:0] nres;
    logic        win_hit;
    logic        sw_start;
    logic        trig;
    logic        clr_rdy;

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    ascv_sync #(.W(1)) u_ev_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      (event_in),
        .q      (ev_q)
    );

    ascv_sync #(.W(10)) u_data_sync (
        .clk    (ref_clk),
        .arst_n (arst_n),
        .d      (adc_data),
        .q      (data_q)
    );

    if (ADC_BITS != 10) begin : g_bad
        $error("ascv_seq supports only a 10-bit converter");
    end

    //------------------------------------------------------------
    // Register writes
    //------------------------------------------------------------
    // Configuration fields
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            enable    <= 1'b0;
            cont_mode <= 1'b0;
            res_low   <= 1'b0;
            acc_sel   <= 3'h0;
            div_sel   <= 3'h0;
            ref_sel   <= 2'h0;
            samp_dly  <= 4'h0;
            vary_en   <= 1'b0;
            samp_len  <= 5'h00;
            chan_sel  <= 5'h00;
            ev_en     <= 1'b0;
            irq_en    <= 2'h0;
            win_lo    <= ascv_pkg::RST_REG;
            win_hi    <= ascv_pkg::RST_WINHI;
            win_mode  <= ascv_pkg::WIN_OFF;
        end else if (wr) begin
            if (addr == ascv_pkg::OFS_CTRL) begin
                enable    <= wdata[ascv_pkg::BIT_ENABLE];
                cont_mode <= wdata[ascv_pkg::BIT_CONT];
                res_low   <= wdata[ascv_pkg::BIT_RESLOW];
            end else if (addr == ascv_pkg::OFS_ACCUM) begin
                acc_sel <= (wdata[2:0] > ascv_pkg::ACC_MAX) ? ascv_pkg::ACC_MAX : wdata[2:0];
            end else if (addr == ascv_pkg::OFS_CLKREF) begin
                div_sel <= wdata[2:0];
                ref_sel <= wdata[ascv_pkg::POS_REF +: 2];
            end else if (addr == ascv_pkg::OFS_SDELAY) begin
                samp_dly <= wdata[3:0];
                vary_en  <= wdata[ascv_pkg::BIT_VARY];
            end else if (addr == ascv_pkg::OFS_SLEN) begin
                samp_len <= wdata[4:0];
            end else if (addr == ascv_pkg::OFS_CHAN) begin
                chan_sel <= wdata[4:0];
            end else if (addr == ascv_pkg::OFS_EVCTRL) begin
                ev_en <= wdata[0];
            end else if (addr == ascv_pkg::OFS_IRQEN) begin
                irq_en <= wdata[1:0];
            end else if (addr == ascv_pkg::OFS_WINLO) begin
                win_lo <= wdata;
            end else if (addr == ascv_pkg::OFS_WINHI) begin
                win_hi <= wdata;
            end else if (addr == ascv_pkg::OFS_WINMODE) begin
                win_mode <= wdata[2:0];
            end
        end
    end

    //------------------------------------------------------------
    // Triggers and timing terms
    //------------------------------------------------------------
    // Software start, event edge, clock tick and sample length
    always_comb begin
        sw_start  = wr && addr == ascv_pkg::OFS_CMD && wdata[0];
        trig      = enable && (sw_start || (ev_en && ev_q && !ev_d)); // R8
        fac       = ascv_pkg::DIV_MIN << div_sel;
        tick      = st == ascv_pkg::ASCV_RUN && pcnt == (fac >> 1);
        eff_dly   = {1'b0, samp_dly} + {3'b000, vary_en ? lfsr[1:0] : 2'b00}; // R17
        samp_time = ascv_pkg::SAMP_BASE + {2'b00, eff_dly} + {2'b00, samp_len}; // R14
        total     = ascv_pkg::CONV_BASE + {2'b00, eff_dly} + {2'b00, samp_len}; // R15
        need      = 7'h01 << acc_sel; // R16
        last_cyc  = tick && cyc == total - 7'h01;
        done_last = last_cyc && nsamp == need - 7'h01;
        smp       = res_low ? {8'h00, data_q[9:2]} : {6'h00, data_q}; // R1
        nres      = acc + smp;
        clr_rdy   = (wr && addr == ascv_pkg::OFS_FLAGS && wdata[ascv_pkg::BIT_RESULT_READY_FLAG])
                  || (rd && addr == ascv_pkg::OFS_RESULT); // R13
    end

    // Window compare on the finished result
    always_comb begin
        case (win_mode)
            ascv_pkg::WIN_BELOW: win_hit = nres < win_lo;
            ascv_pkg::WIN_ABOVE: win_hit = nres > win_hi;
            ascv_pkg::WIN_IN:    win_hit = nres > win_lo && nres < win_hi;
            ascv_pkg::WIN_OUT:   win_hit = nres < win_lo || nres > win_hi;
            default:             win_hit = 1'b0;
        endcase
    end

    // Event edge history
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_d <= 1'b0;
        end else begin
            ev_d <= ev_q;
        end
    end

    //------------------------------------------------------------
    // Start bit and state
    //------------------------------------------------------------
    // Start bit: set by trigger, cleared at single completion
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            start <= 1'b0;
        end else if (!enable) begin
            start <= 1'b0;
        end else if (trig && !start) begin
            start <= 1'b1; // R3 R23
        end else if (done_last && !cont_mode) begin
            start <= 1'b0; // R4
        end
    end

    // Idle or converting; a trigger while running is dropped
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ascv_pkg::ASCV_IDLE;
        end else begin
            case (st)
                ascv_pkg::ASCV_IDLE: begin
                    if (trig && !start) begin
                        st <= ascv_pkg::ASCV_RUN; // R11
                    end
                end
                ascv_pkg::ASCV_RUN: begin
                    if (!enable) begin
                        st <= ascv_pkg::ASCV_IDLE;
                    end else if (done_last && !cont_mode) begin
                        st <= ascv_pkg::ASCV_IDLE; // R9
                    end
                end
                default: st <= ascv_pkg::ASCV_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // Prescaler and converter cycle counters
    //------------------------------------------------------------
    // Prescaler, held at zero while idle or disabled
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pcnt <= 9'h000;
        end else if (!enable || st == ascv_pkg::ASCV_IDLE) begin
            pcnt <= 9'h000; // R10 R11
        end else if (pcnt == fac - 9'h001) begin
            pcnt <= 9'h000;
        end else begin
            pcnt <= pcnt + 9'h001;
        end
    end

    // Converter cycle within one sample
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cyc <= 7'h00;
        end else if (st == ascv_pkg::ASCV_IDLE) begin
            cyc <= 7'h00;
        end else if (tick) begin
            cyc <= last_cyc ? 7'h00 : cyc + 7'h01; // R12 R15
        end
    end

    // Sample count within a burst and delay variation
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nsamp <= 7'h00;
            lfsr  <= ascv_pkg::LFSR_SEED;
        end else if (st == ascv_pkg::ASCV_IDLE) begin
            nsamp <= 7'h00;
        end else if (last_cyc) begin
            nsamp <= done_last ? 7'h00 : nsamp + 7'h01;
            lfsr  <= {lfsr[2:0], lfsr[3] ^ lfsr[2]}; // R17
        end
    end

    //------------------------------------------------------------
    // Accumulation, result and flags
    //------------------------------------------------------------
    // Sum the burst, publish at its end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc    <= ascv_pkg::RST_REG;
            result <= ascv_pkg::RST_REG;
        end else if (st == ascv_pkg::ASCV_IDLE) begin
            acc <= ascv_pkg::RST_REG;
        end else if (done_last) begin
            acc    <= ascv_pkg::RST_REG;
            result <= nres; // R1 R12 R16
        end else if (last_cyc) begin
            acc <= nres;
        end
    end

    // Sticky flags; a set beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags <= 2'h0;
        end else begin
            flags[ascv_pkg::BIT_RESULT_READY_FLAG] <= done_last
                || (flags[ascv_pkg::BIT_RESULT_READY_FLAG] && !clr_rdy); // R6 R13
            flags[ascv_pkg::BIT_WINDOW] <= (done_last && win_hit)
                || (flags[ascv_pkg::BIT_WINDOW]
                && !(wr && addr == ascv_pkg::OFS_FLAGS
                && wdata[ascv_pkg::BIT_WINDOW])); // R18 R22
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    // Interrupt, sampling window, locked selections
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq         <= 1'b0;
            adc_on      <= 1'b0;
            sample_hold <= 1'b0;
            chan_out    <= 5'h00;
            ref_out     <= 2'h0;
        end else begin
            irq         <= |(flags & irq_en); // R7
            adc_on      <= enable;
            sample_hold <= st == ascv_pkg::ASCV_RUN && cyc < samp_time; // R14
            if (enable && (st == ascv_pkg::ASCV_IDLE || last_cyc)) begin
                chan_out <= chan_sel; // R2 R5 R21
                ref_out  <= ref_sel; // R21
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= ascv_pkg::RST_REG;
        end else if (!rd) begin
            rdata <= ascv_pkg::RST_REG;
        end else if (addr == ascv_pkg::OFS_CTRL) begin
            rdata <= {13'h0000, res_low, cont_mode, enable};
        end else if (addr == ascv_pkg::OFS_ACCUM) begin
            rdata <= {13'h0000, acc_sel};
        end else if (addr == ascv_pkg::OFS_CLKREF) begin
            rdata <= {10'h000, ref_sel, 1'b0, div_sel};
        end else if (addr == ascv_pkg::OFS_SDELAY) begin
            rdata <= {11'h000, vary_en, samp_dly};
        end else if (addr == ascv_pkg::OFS_SLEN) begin
            rdata <= {11'h000, samp_len};
        end else if (addr == ascv_pkg::OFS_CHAN) begin
            rdata <= {11'h000, chan_sel};
        end else if (addr == ascv_pkg::OFS_CMD) begin
            rdata <= {15'h0000, start}; // R3
        end else if (addr == ascv_pkg::OFS_EVCTRL) begin
            rdata <= {15'h0000, ev_en};
        end else if (addr == ascv_pkg::OFS_IRQEN) begin
            rdata <= {14'h0000, irq_en};
        end else if (addr == ascv_pkg::OFS_FLAGS) begin
            rdata <= {14'h0000, flags};
        end else if (addr == ascv_pkg::OFS_RESULT) begin
            rdata <= result;
        end else if (addr == ascv_pkg::OFS_WINLO) begin
            rdata <= win_lo;
        end else if (addr == ascv_pkg::OFS_WINHI) begin
            rdata <= win_hi;
        end else if (addr == ascv_pkg::OFS_WINMODE) begin
            rdata <= {13'h0000, win_mode};
        end else begin
            rdata <= ascv_pkg::RST_REG;
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_launch;
        trig && !start ##1 start && st == ascv_pkg::ASCV_RUN;
    endsequence
    property p_launch;
        s_launch |-> pcnt == 9'h000 && cyc == 7'h00;
    endproperty
    a_launch: assert property (p_launch) else $error("start not launched"); // R3

    property p_single_clear;
        done_last && !cont_mode && enable |=> !start && st == ascv_pkg::ASCV_IDLE;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("start not cleared"); // R4

    property p_free_run;
        done_last && cont_mode && enable |=> start && st == ascv_pkg::ASCV_RUN;
    endproperty
    a_free_run: assert property (p_free_run) else $error("free run stopped"); // R9

    property p_rdy_set;
        done_last |=> flags[ascv_pkg::BIT_RESULT_READY_FLAG] && result == $past(nres);
    endproperty
    a_rdy_set: assert property (p_rdy_set) else $error("result not flagged"); // R6

    property p_irq;
        flags[0] && irq_en[0] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // R7

    property p_idle_hold;
        $past(st) == ascv_pkg::ASCV_IDLE |-> pcnt == 9'h000;
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("prescaler ran idle"); // R11

    property p_read_clear;
        rd && addr == ascv_pkg::OFS_RESULT && !done_last |=> !flags[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared"); // R13

    property p_ignore;
        st == ascv_pkg::ASCV_RUN && trig && !last_cyc
            |=> start && cyc == $past(cyc) + {6'h00, $past(tick)};
    endproperty
    a_ignore: assert property (p_ignore) else $error("retriggered"); // R23
endmodule // ascv_seq

`default_nettype wire

//--- ascv_front_model.sv
// Front-end model: the analog converter word seen by the sequencer.
// Assumes adc_on from the sequencer powers the converter.
`timescale 1ns/1ps
`default_nettype none
module ascv_front_model #(
    parameter logic [9:0] VAL = 10'h155    // Converted level
) (
    input  wire logic       ref_clk,       // Peripheral clock
    input  wire logic       adc_on,        // Converter powered
    output logic      [9:0] adc_data       // Conversion word
);
    logic [9:0] junk = 10'h3a5;            // Churning value while off
    // Unpowered front end never repeats its last word
    always @(posedge ref_clk) junk <= ~junk + 10'h001;
    assign adc_data = adc_on ? VAL : junk;
endmodule // ascv_front_model
`default_nettype wire

//--- ascv_tb.sv
// Self-checking bench: register-port tasks and conversion scenarios.
// Assumes the front-end model returns a fixed level when powered.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
    logic        ref_clk  = 1'b0;     // Clock
    logic        arst_n   = 1'b0;     // Reset, active low
    logic [3:0]  addr     = 4'h0;     // Address
    logic [15:0] wdata    = 16'h0000; // Write data
    logic        wr       = 1'b0;     // Write strobe
    logic        rd       = 1'b0;     // Read strobe
    logic        event_in = 1'b0;     // Event trigger
    logic [15:0] rdata;               // Read data
    logic        irq;                 // Interrupt
    logic        adc_on;              // Powered
    logic        sample_hold;         // Sampling
    logic [9:0]  adc_data;            // Front-end word
    logic [4:0]  chan_out;            // Applied channel
    logic [1:0]  ref_out;             // Applied reference
    logic [15:0] v;                   // Read value
    int          err_total = 0;       // Mismatches
    int          comparisons = 0;     // Comparisons
    int          n;                   // Cycle count
    int          k;                   // Poll count

    always #5 ref_clk = ~ref_clk;

    ascv_seq uut (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .event_in(event_in), .adc_data(adc_data),
        .irq(irq), .adc_on(adc_on), .sample_hold(sample_hold), .chan_out(chan_out),
        .ref_out(ref_out));
    ascv_front_model fe (.ref_clk(ref_clk), .adc_on(adc_on), .adc_data(adc_data));

    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_span(input string s, input int lo, input int hi);
        comparisons++;
        if (n < lo || n > hi) begin
            err_total++;
            $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, n);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string s);
        rd_reg(a, v);
        chk(s, e, v);
    endtask
    // Bounded wait for the interrupt line
    task automatic wait_irq();
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (irq !== 1'b1 && n < 9000);
    endtask
    task automatic close_out();
        $display("counts: %0d mismatches, %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (50000) @(posedge ref_clk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_chk(ascv_pkg::OFS_CTRL, 16'h0000, "ctrl");
        rd_chk(ascv_pkg::OFS_WINHI, 16'hffff, "winhi");
        wr_reg(4'he, 16'h1234);
        rd_chk(4'he, 16'h0000, "unmapped");
        wr_reg(ascv_pkg::OFS_CHAN, 16'h0005);
        wr_reg(ascv_pkg::OFS_CLKREF, 16'h0026);
        rd_reg(ascv_pkg::OFS_CTRL, v);
        chk("chan_off", 16'h0000, {9'h0, ref_out, chan_out});
        $display("done reset");
        wr_reg(ascv_pkg::OFS_IRQEN, 16'h0001);
        wr_reg(ascv_pkg::OFS_CTRL, 16'h0001);
        rd_reg(ascv_pkg::OFS_CTRL, v);
        chk("chan_on", 16'h0045, {9'h0, ref_out, chan_out});
        chk("adc_on", 16'h0001, {15'h0, adc_on});
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        rd_chk(ascv_pkg::OFS_CMD, 16'h0001, "busy");
        chk("hold", 16'h0001, {15'h0, sample_hold});
        repeat (6) @(posedge ref_clk);
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        wait_irq();
        chk_span("single", 1585, 1600);
        rd_chk(ascv_pkg::OFS_CMD, 16'h0000, "done");
        rd_chk(ascv_pkg::OFS_RESULT, 16'h0155, "result");
        rd_chk(ascv_pkg::OFS_FLAGS, 16'h0000, "rd_clr");
        $display("done single");
        wr_reg(ascv_pkg::OFS_SDELAY, 16'h0003);
        wr_reg(ascv_pkg::OFS_SLEN, 16'h0004);
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        wait_irq();
        chk_span("delayed", 2490, 2510);
        wr_reg(ascv_pkg::OFS_SLEN, 16'h0000);
        wr_reg(ascv_pkg::OFS_IRQEN, 16'h0000);
        wr_reg(ascv_pkg::OFS_FLAGS, 16'h0001);
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        k = 0;
        do begin
            rd_reg(ascv_pkg::OFS_FLAGS, v);
            k++;
        end while (v[0] !== 1'b1 && k < 2000);
        chk("poll", 16'h0001, v);
        chk("masked", 16'h0000, {15'h0, irq});
        wr_reg(ascv_pkg::OFS_FLAGS, 16'h0001);
        rd_chk(ascv_pkg::OFS_FLAGS, 16'h0000, "w1_clr");
        $display("done delays");
        wr_reg(ascv_pkg::OFS_IRQEN, 16'h0001);
        wr_reg(ascv_pkg::OFS_SDELAY, 16'h0010);
        wr_reg(ascv_pkg::OFS_ACCUM, 16'h0002);
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        wait_irq();
        chk_span("accum", 6700, 8200);
        rd_chk(ascv_pkg::OFS_RESULT, 16'h0554, "sum");
        wr_reg(ascv_pkg::OFS_ACCUM, 16'h0000);
        wr_reg(ascv_pkg::OFS_EVCTRL, 16'h0001);
        @(posedge ref_clk);
        event_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        event_in <= 1'b0;
        wait_irq();
        chk_span("event", 1550, 2050);
        rd_chk(ascv_pkg::OFS_CMD, 16'h0000, "ev_done");
        wr_reg(ascv_pkg::OFS_EVCTRL, 16'h0000);
        $display("done accum and event");
        wr_reg(ascv_pkg::OFS_WINLO, 16'h0100);
        wr_reg(ascv_pkg::OFS_WINHI, 16'h0200);
        for (int m = 1; m <= 4; m++) begin
            wr_reg(ascv_pkg::OFS_FLAGS, 16'h0003);
            wr_reg(ascv_pkg::OFS_WINMODE, 16'(m));
            wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
            wait_irq();
            rd_chk(ascv_pkg::OFS_FLAGS, (m == 3) ? 16'h0003 : 16'h0001, "window");
        end
        wr_reg(ascv_pkg::OFS_WINMODE, 16'h0000);
        wr_reg(ascv_pkg::OFS_FLAGS, 16'h0003);
        $display("done window");
        wr_reg(ascv_pkg::OFS_CTRL, 16'h0003);
        wr_reg(ascv_pkg::OFS_CMD, 16'h0001);
        wr_reg(ascv_pkg::OFS_CHAN, 16'h0009);
        chk("chan_lock", 16'h0005, {11'h0, chan_out});
        wait_irq();
        rd_reg(ascv_pkg::OFS_RESULT, v);
        @(negedge ref_clk);
        wait_irq();
        chk_span("period", 1600, 2100);
        rd_chk(ascv_pkg::OFS_CMD, 16'h0001, "free");
        chk("chan_new", 16'h0009, {11'h0, chan_out});
        wr_reg(ascv_pkg::OFS_CTRL, 16'h0000);
        rd_chk(ascv_pkg::OFS_CMD, 16'h0000, "abort");
        chk("adc_off", 16'h0000, {15'h0, adc_on});
        $display("done free run");
        close_out();
    end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
